// ### hdl/capture_flag_pkg.sv
// Package for the input capture flag block: register map, field layout,
// reset values, bus answers and the shared carrier types.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
package capture_flag_pkg;

	localparam int ADDR_W = 8;
	localparam int COUNT_W = 16;

	// Register byte addresses
	localparam logic [ADDR_W-1:0] TIMER_CONTROL_STATUS_OFFSET = 8'h00;
	localparam logic [ADDR_W-1:0] CTRL_OFFSET = 8'h04;
	localparam logic [ADDR_W-1:0] IEN_OFFSET = 8'h08;
	localparam logic [ADDR_W-1:0] CAP_A_OFFSET = 8'h0C;
	localparam logic [ADDR_W-1:0] CAP_B_OFFSET = 8'h10;
	localparam logic [ADDR_W-1:0] CAP_C_OFFSET = 8'h14;
	localparam logic [ADDR_W-1:0] CAP_D_OFFSET = 8'h18;
	localparam logic [ADDR_W-1:0] COUNT_OFFSET = 8'h1C;

	// Flags A, B, C sit in bits 7..5 of the status and enable registers
	localparam int FLAG_LSB = 5;
	localparam int FLAG_A_BIT = 7;
	localparam int FLAG_B_BIT = 6;
	localparam int FLAG_C_BIT = 5;

	// Control register fields
	localparam int BUF_A_BIT = 0;
	localparam int BUF_B_BIT = 1;
	localparam int EDGE_A_BIT = 2;
	localparam int EDGE_B_BIT = 3;
	localparam int EDGE_C_BIT = 4;

	// Reset values
	localparam logic [2:0] FLAGS_RESET = 3'h0;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] IEN_RESET = 8'h00;
	localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// One bit per capture channel; a is the most significant
	typedef struct packed {
		logic a;
		logic b;
		logic c;
	} chan_type;

	typedef enum logic {
		WR_IDLE,
		WR_RESP
	} wr_state_type;

endpackage : capture_flag_pkg

// ### hdl/capture_flag_status_abc.sv
// Input capture flags A, B, C with buffer modes, a free-running counter,
// capture registers and an AXI4-Lite register slave.
// Assumes capture pins are asynchronous; all else runs on aclk.
module capture_flag_status_abc
	import capture_flag_pkg::*;
#(
	parameter int SYNC_STAGES = 2
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [capture_flag_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [capture_flag_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire capture_flag_pkg::chan_type capture_pin,
	output capture_flag_pkg::chan_type capture_irq,
	output logic irq
);
	import capture_flag_pkg::*;

	// Elaboration check: the edge detector is built for two stages only
	if (SYNC_STAGES != 2) begin : g_sync_check
		$error("SYNC_STAGES must be 2");
	end

	function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
		is_mapped = (a == TIMER_CONTROL_STATUS_OFFSET) || (a == CTRL_OFFSET) || (a == IEN_OFFSET) ||
			(a == CAP_A_OFFSET) || (a == CAP_B_OFFSET) || (a == CAP_C_OFFSET) ||
			(a == CAP_D_OFFSET) || (a == COUNT_OFFSET);
	endfunction : is_mapped

	// Pin synchroniser and edge detector
	chan_type sync1_q, sync2_q, prev_q;
	chan_type sync1_d, sync2_d, prev_d;
	chan_type ev;
	logic [7:0] ctrl_q;

	always_comb begin
		sync1_d = capture_pin;
		sync2_d = sync1_q;
		prev_d = sync2_q;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1_q <= '0;
			sync2_q <= '0;
			prev_q <= '0;
		end else begin
			sync1_q <= sync1_d;
			sync2_q <= sync2_d;
			prev_q <= prev_d;
		end
	end

	// Edge select one means rising, zero means falling
	always_comb begin
		ev.a = ctrl_q[EDGE_A_BIT] ? (sync2_q.a & ~prev_q.a) : (~sync2_q.a & prev_q.a);
		ev.b = ctrl_q[EDGE_B_BIT] ? (sync2_q.b & ~prev_q.b) : (~sync2_q.b & prev_q.b);
		ev.c = ctrl_q[EDGE_C_BIT] ? (sync2_q.c & ~prev_q.c) : (~sync2_q.c & prev_q.c);
	end

	// Register and bus state
	wr_state_type wr_state_q, wr_state_d;
	logic aw_have_q, aw_have_d, w_have_q, w_have_d;
	logic [ADDR_W-1:0] awaddr_q, awaddr_d;
	logic [31:0] wdata_q, wdata_d;
	logic [3:0] wstrb_q, wstrb_d;
	logic awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
	logic [1:0] bresp_d, rresp_d;
	logic [31:0] rdata_d;
	logic [2:0] flags_q, flags_d, armed_q, armed_d;
	logic [7:0] ctrl_d, ien_q, ien_d;
	logic [COUNT_W-1:0] count_q, count_d;
	logic [COUNT_W-1:0] cap_a_q, cap_a_d, cap_b_q, cap_b_d, cap_c_q, cap_c_d, cap_d_q, cap_d_d;
	chan_type irq_ch_d;
	logic irq_d;
	logic wr_go, rd_go, wr_timer_control_status_go, rd_timer_control_status_go;
	logic [2:0] set_v, clr_v, ien_flags;

	always_comb begin
		wr_state_d = wr_state_q;
		aw_have_d = aw_have_q;
		w_have_d = w_have_q;
		awaddr_d = awaddr_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		bvalid_d = s_axi_bvalid;
		bresp_d = s_axi_bresp;
		rvalid_d = s_axi_rvalid;
		rresp_d = s_axi_rresp;
		rdata_d = s_axi_rdata;
		ctrl_d = ctrl_q;
		ien_d = ien_q;
		count_d = count_q + 16'h0001;
		cap_a_d = cap_a_q;
		cap_b_d = cap_b_q;
		cap_c_d = cap_c_q;
		cap_d_d = cap_d_q;
		clr_v = 3'h0;
		armed_d = armed_q;

		// Write channel: address and data may come in either order
		if (s_axi_awvalid && s_axi_awready) begin
			aw_have_d = 1'b1;
			awaddr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_have_d = 1'b1;
			wdata_d = s_axi_wdata;
			wstrb_d = s_axi_wstrb;
		end
		wr_go = (wr_state_q == WR_IDLE) && aw_have_q && w_have_q;
		wr_timer_control_status_go = wr_go && (awaddr_q == TIMER_CONTROL_STATUS_OFFSET) && wstrb_q[0];
		case (wr_state_q)
			WR_IDLE: begin
				if (wr_go) begin
					aw_have_d = 1'b0;
					w_have_d = 1'b0;
					bvalid_d = 1'b1;
					bresp_d = is_mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
					wr_state_d = WR_RESP;
					if (wstrb_q[0] && awaddr_q == CTRL_OFFSET) begin
						ctrl_d = wdata_q[7:0];
					end
					if (wstrb_q[0] && awaddr_q == IEN_OFFSET) begin
						ien_d = wdata_q[7:0];
					end
				end
			end
			WR_RESP: begin
				if (s_axi_bready) begin
					bvalid_d = 1'b0;
					wr_state_d = WR_IDLE;
				end
			end
			default: begin
				wr_state_d = WR_IDLE;
			end
		endcase

		// Only zeros act; ones written are ignored
		// A zero clears only a flag that was read as one
		if (wr_timer_control_status_go) begin
			clr_v = armed_q & ~wdata_q[7:FLAG_LSB];
			armed_d = armed_q & ~clr_v;
		end

		// Read channel
		rd_go = s_axi_arvalid && s_axi_arready;
		rd_timer_control_status_go = rd_go && (s_axi_araddr == TIMER_CONTROL_STATUS_OFFSET);
		if (s_axi_rvalid && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
		if (rd_go) begin
			rvalid_d = 1'b1;
			rresp_d = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			case (s_axi_araddr)
				TIMER_CONTROL_STATUS_OFFSET: rdata_d = {24'h000000, flags_q, 5'h00};
				CTRL_OFFSET: rdata_d = {24'h000000, ctrl_q};
				IEN_OFFSET: rdata_d = {24'h000000, ien_q};
				CAP_A_OFFSET: rdata_d = {16'h0000, cap_a_q};
				CAP_B_OFFSET: rdata_d = {16'h0000, cap_b_q};
				CAP_C_OFFSET: rdata_d = {16'h0000, cap_c_q};
				CAP_D_OFFSET: rdata_d = {16'h0000, cap_d_q};
				COUNT_OFFSET: rdata_d = {16'h0000, count_q};
				default: rdata_d = 32'h00000000;
			endcase
		end
		// Reading a set flag arms its clear
		if (rd_timer_control_status_go) begin
			armed_d = armed_d | flags_q;
		end

		// Capture C loads the count only outside buffer mode A
		if (ev.c && !ctrl_q[BUF_A_BIT]) begin
			cap_c_d = count_q;
		end
		// Channel A capture, old value to C in buffer mode
		if (ev.a) begin
			cap_a_d = count_q;
			if (ctrl_q[BUF_A_BIT]) begin
				cap_c_d = cap_a_q;
			end
		end
		// Channel B capture, old value to D in buffer mode
		if (ev.b) begin
			cap_b_d = count_q;
			if (ctrl_q[BUF_B_BIT]) begin
				cap_d_d = cap_b_q;
			end
		end

		// Set wins over a clear in the same cycle
		set_v = {ev.a, ev.b, ev.c};
		flags_d = (flags_q & ~clr_v) | set_v;
		armed_d = armed_d & flags_d & ~set_v;

		// Per-channel request from flag and enable
		ien_flags = ien_d[FLAG_A_BIT:FLAG_C_BIT];
		irq_ch_d = flags_d & ien_flags;
		irq_d = |irq_ch_d;

		awready_d = (wr_state_d == WR_IDLE) && !aw_have_d;
		wready_d = (wr_state_d == WR_IDLE) && !w_have_d;
		arready_d = !rvalid_d;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_state_q <= WR_IDLE;
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= RESP_OKAY;
			s_axi_rdata <= 32'h00000000;
			flags_q <= FLAGS_RESET;
			armed_q <= 3'h0;
			ctrl_q <= CTRL_RESET;
			ien_q <= IEN_RESET;
			count_q <= COUNT_RESET;
			cap_a_q <= COUNT_RESET;
			cap_b_q <= COUNT_RESET;
			cap_c_q <= COUNT_RESET;
			cap_d_q <= COUNT_RESET;
			capture_irq <= '0;
			irq <= 1'b0;
		end else begin
			wr_state_q <= wr_state_d;
			aw_have_q <= aw_have_d;
			w_have_q <= w_have_d;
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			s_axi_awready <= awready_d;
			s_axi_wready <= wready_d;
			s_axi_bvalid <= bvalid_d;
			s_axi_bresp <= bresp_d;
			s_axi_arready <= arready_d;
			s_axi_rvalid <= rvalid_d;
			s_axi_rresp <= rresp_d;
			s_axi_rdata <= rdata_d;
			flags_q <= flags_d;
			armed_q <= armed_d;
			ctrl_q <= ctrl_d;
			ien_q <= ien_d;
			count_q <= count_d;
			cap_a_q <= cap_a_d;
			cap_b_q <= cap_b_d;
			cap_c_q <= cap_c_d;
			cap_d_q <= cap_d_d;
			capture_irq <= irq_ch_d;
			irq <= irq_d;
		end
	end

	// Checks
	localparam int CLR_WAIT_MIN = 1;
	localparam int CLR_WAIT_MAX = 20;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence s_read_set_a;
		rd_timer_control_status_go && flags_q[2];
	endsequence

	sequence s_zero_write_a;
		wr_timer_control_status_go && !wdata_q[FLAG_A_BIT] && !ev.a && armed_q[2];
	endsequence

	a_flag_a_set: assert property (ev.a |=> flags_q[2])
		else $error("flag A not set by capture A");
	a_buffer_a_move: assert property (ev.a && ctrl_q[BUF_A_BIT] |=>
		cap_c_q == $past(cap_a_q) && cap_a_q == $past(count_q) && flags_q[2])
		else $error("buffer mode A transfer wrong");
	a_flag_b_set: assert property (ev.b |=> flags_q[1] && cap_b_q == $past(count_q))
		else $error("flag B not set by capture B");
	a_buffer_b_move: assert property (ev.b && ctrl_q[BUF_B_BIT] |=>
		cap_d_q == $past(cap_b_q) && flags_q[1])
		else $error("buffer mode B transfer wrong");
	a_flag_c_set: assert property ($rose(sync2_q.c) && ctrl_q[EDGE_C_BIT] |=> flags_q[0])
		else $error("flag C not set by chosen edge");
	a_c_no_load: assert property (ev.c && ctrl_q[BUF_A_BIT] && !ev.a |=> $stable(cap_c_q))
		else $error("capture C loaded in buffer mode A");
	a_pin_c_irq: assert property (ev.c && ctrl_q[BUF_A_BIT] && ien_q[FLAG_C_BIT] && !wr_go
		|=> capture_irq.c && irq)
		else $error("pin C interrupt missing in buffer mode A");
	a_write_no_set: assert property (wr_timer_control_status_go && set_v == 3'h0 |=> (flags_q & ~$past(flags_q)) == 3'h0)
		else $error("write set a flag");
	a_clear_needs_read: assert property (wr_timer_control_status_go && flags_q[2] && !armed_q[2] |=> flags_q[2])
		else $error("flag A cleared without prior read");
	a_read_then_clear: assert property (s_read_set_a ##[CLR_WAIT_MIN:CLR_WAIT_MAX] s_zero_write_a
		|=> !flags_q[2])
		else $error("flag A not cleared after read and zero write");
	a_flags_reset: assert property (@(posedge aclk) disable iff (1'b0) !aresetn |=> flags_q == 3'h0)
		else $error("flags not zero after reset");
	a_irq_a_level: assert property (capture_irq.a == (flags_q[2] && ien_q[FLAG_A_BIT]))
		else $error("interrupt A does not follow flag and enable");
	a_set_wins: assert property (wr_timer_control_status_go && set_v != 3'h0 |=> (flags_q & $past(set_v)) == $past(set_v))
		else $error("event lost on clearing write");

endmodule : capture_flag_status_abc

// ### verification/capture_pin_model.sv
// Behavioural stand-in for the sources driving the three capture pins.
// Assumes the bench calls pulse() or set_pin() from its main sequence after a clock edge.
module capture_pin_model (
	input wire logic aclk,
	output capture_flag_pkg::chan_type capture_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	import capture_flag_pkg::*;

	initial capture_pin = 3'h7;

	// Idle high, low for three cycles, then high again: one falling and one rising edge.
	// Three cycles is more than the one-cycle minimum that the synchroniser and edge detector need.
	task automatic pulse(input int ch);
		begin
			capture_pin[ch] <= 1'b0;
			repeat (3) @(posedge aclk);
			capture_pin[ch] <= 1'b1;
			repeat (6) @(posedge aclk);
		end
	endtask : pulse

	// Single level change, for lining an edge up with a bus access
	task automatic set_pin(input int ch, input logic val);
		capture_pin[ch] <= val;
	endtask : set_pin
endmodule : capture_pin_model

// ### verification/tb_capture_flag_status_abc.sv
// Self-checking bench for the capture flag block over AXI4-Lite.
// Assumes the capture_pin_model drives the pins; bready and rready rise only while an answer is awaited.
module tb_capture_flag_status_abc;
	timeunit 1ns;
	timeprecision 1ns;
	import capture_flag_pkg::*;

	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic arvalid = 1'b0;
	logic bready = 1'b0;
	logic rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0] bresp, rresp, rs;
	logic [31:0] rdata, v, r;
	chan_type pins, cirq;
	int errors = 0;
	int tests_run = 0;
	int cycles = 0;

	always #10 aclk = ~aclk;

	capture_flag_status_abc u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.capture_pin(pins), .capture_irq(cirq), .irq(irq));

	capture_pin_model u_pins (.aclk(aclk), .capture_pin(pins));

	task automatic finish_test;
		$display("Comparisons %0d, mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : finish_test

	task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF,
		input logic [1:0] e = RESP_OKAY);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (!aw_ok && awready === 1'b1) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_ok && wready === 1'b1) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		bready <= 1'b1;
		do @(posedge aclk); while (bvalid !== 1'b1);
		bready <= 1'b0;
		check("bresp", {30'h0, e}, {30'h0, bresp});
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] s);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do @(posedge aclk); while (rvalid !== 1'b1);
		rready <= 1'b0;
		d = rdata;
		s = rresp;
	endtask : rd

	task automatic chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] s;
		rd(a, d, s);
		check("rresp", 32'h0, {30'h0, s});
		check($sformatf("reg %h", a), e, d);
	endtask : chk

	// A hang ends the run as a failure
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 5000) begin
			errors++;
			finish_test();
		end
	end

	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		chk(TIMER_CONTROL_STATUS_OFFSET, 32'h0);
		chk(CTRL_OFFSET, 32'h0);
		chk(IEN_OFFSET, 32'h0);
		wr(IEN_OFFSET, 32'h80);
		u_pins.pulse(2);
		check("capture_irq", 32'h4, {29'h0, cirq});
		check("irq", 32'h1, {31'h0, irq});
		chk(TIMER_CONTROL_STATUS_OFFSET, 32'h80);
		wr(TIMER_CONTROL_STATUS_OFFSET, 32'hFF);
		chk(TIMER_CONTROL_STATUS_OFFSET, 32'h80);
		wr(IEN_OFFSET, 32'h00);
		repeat (2) @(posedge aclk);
		check("irq masked", 32'h0, {31'h0, irq});
		wr(TIMER_CONTROL_STATUS_OFFSET, 32'h0);
		chk(TIMER_CONTROL_STATUS_OFFSET, 32'h0);
		u_pins.pulse(1);
		wr(TIMER_CONTROL_STATUS_OFFSET, 32'h0);
		chk(TIMER_CONTROL_STATUS_OFFSET, 32'h40);
		wr(TIMER_CONTROL_STATUS_OFFSET, 32'h0);
		chk(TIMER_CONTROL_STATUS_OFFSET, 32'h0);
		// Buffer mode A, with C as an external interrupt
		wr(CTRL_OFFSET, 32'h01);
		wr(IEN_OFFSET, 32'h20);
		u_pins.pulse(2);
		rd(CAP_A_OFFSET, v, rs);
		u_pins.pulse(2);
		chk(CAP_C_OFFSET, v);
		rd(CAP_A_OFFSET, r, rs);
		check("cap_a reloaded", 32'h1, {31'h0, r != v});
		u_pins.pulse(0);
		chk(CAP_C_OFFSET, v);
		check("capture_irq c", 32'h1, {29'h0, cirq});
		chk(TIMER_CONTROL_STATUS_OFFSET, 32'hA0);
		wr(TIMER_CONTROL_STATUS_OFFSET, 32'h0);
		chk(TIMER_CONTROL_STATUS_OFFSET, 32'h0);
		// Buffer mode B
		wr(CTRL_OFFSET, 32'h02);
		u_pins.pulse(1);
		rd(CAP_B_OFFSET, v, rs);
		u_pins.pulse(1);
		chk(CAP_D_OFFSET, v);
		// Rising edge selected on C
		wr(CTRL_OFFSET, 32'h10);
		u_pins.pulse(0);
		chk(TIMER_CONTROL_STATUS_OFFSET, 32'h60);
		rd(8'h40, r, rs);
		check("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, rs});
		check("unmapped rdata", 32'h0, r);
		// Capture event in the very cycle of a clearing write
		u_pins.pulse(2);
		chk(TIMER_CONTROL_STATUS_OFFSET, 32'hE0);
		u_pins.set_pin(2, 1'b0);
		@(posedge aclk);
		wr(TIMER_CONTROL_STATUS_OFFSET, 32'h0);
		u_pins.set_pin(2, 1'b1);
		repeat (4) @(posedge aclk);
		chk(TIMER_CONTROL_STATUS_OFFSET, 32'h80);
		// Writes without the low strobe, and to a hole, change nothing
		wr(CTRL_OFFSET, 32'h0C, 4'h0);
		chk(CTRL_OFFSET, 32'h10);
		wr(8'h40, 32'h1, 4'hF, RESP_SLVERR);
		// Rising edge selected on A and B, with only B enabled
		wr(CTRL_OFFSET, 32'h0C);
		wr(IEN_OFFSET, 32'h40);
		u_pins.pulse(1);
		check("capture_irq b", 32'h2, {29'h0, cirq});
		chk(TIMER_CONTROL_STATUS_OFFSET, 32'hC0);
		finish_test();
	end
endmodule : tb_capture_flag_status_abc
